// >>> hw/fsp_consts.svh
// Purpose: constants of the serial flash status, guard and identification logic
// Assumes: included by bare name, core clock of 40 MHz
// Notes:   times in ns, cycle counts derived from them
`ifndef FSP_CONSTS_SVH
`define FSP_CONSTS_SVH

// opcodes
`define FSP_OP_STATUS_WRITE   8'h01
`define FSP_OP_PAGE_PROGRAM   8'h02
`define FSP_OP_WRITE_FORBID   8'h04
`define FSP_OP_STATUS_READ    8'h05
`define FSP_OP_WRITE_ALLOW    8'h06
`define FSP_OP_SECTOR_ERASE   8'h20
`define FSP_OP_OTP_ENTER      8'h3A
`define FSP_OP_BLOCK_ERASE_A  8'h52
`define FSP_OP_CHIP_ERASE_A   8'h60
`define FSP_OP_ID_PAIR        8'h90
`define FSP_OP_ID_READ        8'h9F
`define FSP_OP_ID_RELEASE     8'hAB
`define FSP_OP_CHIP_ERASE_B   8'hC7
`define FSP_OP_BLOCK_ERASE_B  8'hD8

// frame lengths in bytes, byte indices and last bit index
`define FSP_LEN_SINGLE        3'h1
`define FSP_LEN_STATUS_WRITE  3'h2
`define FSP_LEN_ADDR_CMD      3'h4
`define FSP_LEN_PROGRAM_MIN   3'h5
`define FSP_LEN_SAT           3'h7
`define FSP_IDX_SELECTOR      3'h3
`define FSP_IDX_ID_FIRST      3'h1
`define FSP_IDX_ID_SECOND     3'h2
`define FSP_IDX_ID_THIRD      3'h3
`define FSP_IDX_DUMMY_END     3'h4
`define FSP_BIT_LAST          3'h7

// status byte layout
`define FSP_SB_BUSY           0
`define FSP_SB_WEL            1
`define FSP_SB_GUARD_LO       2
`define FSP_SB_GUARD_HI       4
`define FSP_SB_LOCK           7

// reset values
`define FSP_RST_GUARD         3'h0
`define FSP_RST_LOCK          1'h0
`define FSP_RST_OTP_LOCK      1'h0

// timing
`define FSP_CLK_PERIOD_NS     25
`define FSP_T_STATUS_NS       10000
`define FSP_T_PROGRAM_NS      20000
`define FSP_T_SECTOR_NS       30000
`define FSP_T_BLOCK_NS        40000
`define FSP_T_CHIP_NS         50000
`define FSP_CYC(ns)           (((ns) + `FSP_CLK_PERIOD_NS - 1) / `FSP_CLK_PERIOD_NS)

`endif

// >>> hw/fsp_pkg.sv
// Purpose: types of the serial flash status, guard and identification logic
// Assumes: constants come from fsp_consts.svh
// Notes:   none
package fsp_pkg;

    typedef enum logic [2:0] {
        FSP_KIND_NONE,
        FSP_KIND_STATUS,
        FSP_KIND_PROGRAM,
        FSP_KIND_SECTOR,
        FSP_KIND_BLOCK,
        FSP_KIND_CHIP
    } fsp_kind_t;

endpackage : fsp_pkg

// >>> hw/fsp_top.sv
// Purpose: command logic for status, guard, otp and id of a serial flash
// Assumes: link logic on SPI_CLK, status and cycles on CORE_CLK
// Notes:   frame registers are read by the core only after select has risen
//
// Overview of operation
// - pair id: two dummies, selector, alternating codes
// - release id: three dummies, repeat part code
// - id read: maker, part high, part low
// - all link bytes travel msb first
// - write allow command sets write latch flag
// - writing commands refused while latch clear
// - write forbid clears latch, or leaves otp
// - latch cleared at power-up and cycle end
// - status read accepted at any time
// - status byte repeats while select low
// - busy flag high during write cycles
// - area guard bits block program, erase outside otp
// - chip erase only with guard bits zero
// - status bits five, six read zero
// - status write keeps bits 6,5,1,0
// - lock and guard pin low refuse status writes outside otp
// - in otp mode lock seals otp sector
// - otp status write just sets seal
// - status write needs exactly one data byte
// - status write starts timed busy cycle
// - writing commands must end byte aligned
// - each frame opens with one opcode
`timescale 1ns/1ps
`include "fsp_consts.svh"

module fsp_top
    import fsp_pkg::*;
#(
    parameter logic [7:0] MAKER_CODE   = 8'hA5,  // arbitrary value
    parameter logic [7:0] PART_CODE_HI = 8'h5A,  // arbitrary value
    parameter logic [7:0] PART_CODE_LO = 8'h3C   // arbitrary value
) (
    // core clock and reset
    input  wire logic CORE_CLK,
    input  wire logic RESET,
    // serial link
    input  wire logic SPI_CLK,
    input  wire logic CS_N,
    input  wire logic SERIAL_IN,
    output logic      SERIAL_OUT,
    output logic      SERIAL_OUT_OE_N,
    // guard pin
    input  wire logic WP_N
);

    // ---------------- link domain ----------------
    logic       fresh_reg;
    logic [7:0] shift_reg;
    logic [7:0] shift_next;
    logic [2:0] cnt_reg;
    logic [2:0] cnt_next;
    logic [2:0] byte_reg;
    logic [2:0] byte_next;
    logic       par_reg;
    logic       par_next;
    logic [7:0] op_reg;
    logic [7:0] op_next;
    logic [7:0] b1_reg;
    logic [7:0] b1_next;
    logic [7:0] b2_reg;
    logic [7:0] b2_next;
    logic [7:0] b3_reg;
    logic [7:0] b3_next;
    logic [7:0] tx_reg;
    logic [7:0] tx_next;
    logic       drive_reg;
    logic       drive_next;
    logic [7:0] stat_s1_reg;
    logic [7:0] stat_s2_reg;
    logic [7:0] status_and_protect_reg;
    logic       frame_tog_reg;
    logic [2:0] cnt_eff;
    logic [2:0] byte_eff;
    logic       par_eff;
    logic       done;
    logic [7:0] opc;
    logic       sel;
    logic [8:0] pick;

    // answer byte for byte index idx of the current frame
    function automatic logic [8:0] tx_pick(input logic [7:0] op, input logic [2:0] idx,
                                           input logic par, input logic sel_b,
                                           input logic [7:0] stat);
        logic [8:0] r;
        r = 9'h000;
        unique case (op)
            `FSP_OP_STATUS_READ: begin
                if (idx >= `FSP_IDX_ID_FIRST) begin
                    r = {1'b1, stat};
                end
            end
            `FSP_OP_ID_READ: begin
                if (idx == `FSP_IDX_ID_FIRST) begin
                    r = {1'b1, MAKER_CODE};
                end else if (idx == `FSP_IDX_ID_SECOND) begin
                    r = {1'b1, PART_CODE_HI};
                end else if (idx == `FSP_IDX_ID_THIRD) begin
                    r = {1'b1, PART_CODE_LO};
                end else if (idx > `FSP_IDX_ID_THIRD) begin
                    r = 9'h100;
                end
            end
            `FSP_OP_ID_RELEASE: begin
                if (idx >= `FSP_IDX_DUMMY_END) begin
                    r = {1'b1, PART_CODE_LO};
                end
            end
            `FSP_OP_ID_PAIR: begin
                if (idx >= `FSP_IDX_DUMMY_END) begin
                    r = {1'b1, (sel_b ^ par) ? PART_CODE_LO : MAKER_CODE};
                end
            end
            default: begin
                r = 9'h000;
            end
        endcase
        return r;
    endfunction : tx_pick

    always_comb begin
        cnt_eff    = fresh_reg ? 3'h0 : cnt_reg;
        byte_eff   = fresh_reg ? 3'h0 : byte_reg;
        par_eff    = fresh_reg ? 1'b0 : par_reg;
        shift_next = {shift_reg[6:0], SERIAL_IN};
        done       = (cnt_eff == `FSP_BIT_LAST);
        cnt_next   = cnt_eff + 3'h1;
        byte_next  = (done && byte_eff != `FSP_LEN_SAT) ? byte_eff + 3'h1 : byte_eff;
        par_next   = done ? ~par_eff : par_eff;
        opc        = (byte_eff == 3'h0) ? shift_next : op_reg;
        sel        = (byte_eff == `FSP_IDX_SELECTOR) ? shift_next[0] : b3_reg[0];
        pick       = tx_pick(opc, byte_next, par_next, sel, stat_s2_reg);
        op_next    = (done && byte_eff == 3'h0) ? shift_next : op_reg;
        b1_next    = (done && byte_eff == 3'h1) ? shift_next : b1_reg;
        b2_next    = (done && byte_eff == 3'h2) ? shift_next : b2_reg;
        b3_next    = (done && byte_eff == 3'h3) ? shift_next : b3_reg;
        tx_next    = done ? pick[7:0] : tx_reg;
        drive_next = done ? pick[8] : (byte_eff == 3'h0 ? 1'b0 : drive_reg);
    end

    // frame start marker, set while select is high
    always_ff @(posedge SPI_CLK or posedge CS_N or posedge RESET) begin
        if (RESET || CS_N) begin
            fresh_reg <= 1'b1;
        end else begin
            fresh_reg <= 1'b0;
        end
    end

    // shifting and byte capture
    always_ff @(posedge SPI_CLK or posedge RESET) begin
        if (RESET) begin
            shift_reg <= 8'h00;
            cnt_reg   <= 3'h0;
            byte_reg  <= 3'h0;
            par_reg   <= 1'b0;
            op_reg    <= 8'h00;
            b1_reg    <= 8'h00;
            b2_reg    <= 8'h00;
            b3_reg    <= 8'h00;
            tx_reg    <= 8'h00;
            drive_reg <= 1'b0;
            frame_tog_reg <= 1'b0;
        end else begin
            frame_tog_reg <= fresh_reg ? ~frame_tog_reg : frame_tog_reg;
            shift_reg <= shift_next;
            cnt_reg   <= cnt_next;
            byte_reg  <= byte_next;
            par_reg   <= par_next;
            op_reg    <= op_next;
            b1_reg    <= b1_next;
            b2_reg    <= b2_next;
            b3_reg    <= b3_next;
            tx_reg    <= tx_next;
            drive_reg <= drive_next;
        end
    end

    // status word into the link domain
    always_ff @(posedge SPI_CLK or posedge RESET) begin
        if (RESET) begin
            stat_s1_reg <= 8'h00;
            stat_s2_reg <= 8'h00;
        end else begin
            stat_s1_reg <= status_and_protect_reg;
            stat_s2_reg <= stat_s1_reg;
        end
    end

    // output on falling edge, released as soon as select rises
    always_ff @(negedge SPI_CLK or posedge CS_N or posedge RESET) begin
        if (RESET || CS_N) begin
            SERIAL_OUT      <= 1'b0;
            SERIAL_OUT_OE_N <= 1'b1;
        end else begin
            SERIAL_OUT      <= tx_reg[~cnt_reg];
            SERIAL_OUT_OE_N <= ~drive_reg;
        end
    end

    // ---------------- core domain ----------------
    logic       cs_s1_reg;
    logic       cs_s2_reg;
    logic       cs_s3_reg;
    logic       wp_s1_reg;
    logic       wp_s2_reg;
    logic       tog_seen_reg;
    logic       frame_end;
    logic       aligned;
    logic       busy;
    logic       hardware_guard_mode;
    logic       wel_reg;
    logic [2:0] guard_reg;
    logic       lock_reg;
    logic       otp_lock_reg;
    logic       otp_mode_reg;
    logic [7:0] wr_data_reg;
    fsp_kind_t  kind_reg;
    fsp_kind_t  kind_next;
    logic [15:0] timer_reg;
    logic [15:0] timer_next;
    logic       cycle_done;
    logic       area_blocked;
    logic [7:0] status_next;

    // area guard decode over the top blocks
    function automatic logic guard_hit(input logic [2:0] g, input logic [4:0] blk);
        logic r;
        r = 1'b0;
        unique case (g)
            3'h0: r = 1'b0;
            3'h1: r = (blk >= 5'h1F);
            3'h2: r = (blk >= 5'h1E);
            3'h3: r = (blk >= 5'h1C);
            3'h4: r = (blk >= 5'h18);
            3'h5: r = (blk >= 5'h10);
            3'h6: r = 1'b1;
            3'h7: r = 1'b1;
        endcase
        return r;
    endfunction : guard_hit

    always_ff @(posedge CORE_CLK or posedge RESET) begin
        if (RESET) begin
            cs_s1_reg <= 1'b1;
            cs_s2_reg <= 1'b1;
            cs_s3_reg <= 1'b1;
            wp_s1_reg <= 1'b1;
            wp_s2_reg <= 1'b1;
            tog_seen_reg <= 1'b0;
        end else begin
            tog_seen_reg <= frame_end ? frame_tog_reg : tog_seen_reg;
            cs_s1_reg <= CS_N;
            cs_s2_reg <= cs_s1_reg;
            cs_s3_reg <= cs_s2_reg;
            wp_s1_reg <= WP_N;
            wp_s2_reg <= wp_s1_reg;
        end
    end

    always_comb begin
        frame_end    = cs_s2_reg & ~cs_s3_reg;
        aligned      = (cnt_reg == 3'h0) && (frame_tog_reg != tog_seen_reg);
        busy         = (kind_reg != FSP_KIND_NONE);
        hardware_guard_mode          = lock_reg & ~wp_s2_reg & ~otp_mode_reg;
        area_blocked = otp_mode_reg ? otp_lock_reg : guard_hit(guard_reg, b1_reg[4:0]);
        cycle_done   = busy && (timer_reg == 16'h0000);
        kind_next    = FSP_KIND_NONE;
        if (frame_end && aligned && !busy && wel_reg) begin
            unique case (op_reg)
                `FSP_OP_STATUS_WRITE: begin
                    if (byte_reg == `FSP_LEN_STATUS_WRITE && !hardware_guard_mode) begin
                        kind_next = FSP_KIND_STATUS;
                    end
                end
                `FSP_OP_PAGE_PROGRAM: begin
                    if (byte_reg >= `FSP_LEN_PROGRAM_MIN && !area_blocked) begin
                        kind_next = FSP_KIND_PROGRAM;
                    end
                end
                `FSP_OP_SECTOR_ERASE: begin
                    if (byte_reg == `FSP_LEN_ADDR_CMD && !area_blocked) begin
                        kind_next = FSP_KIND_SECTOR;
                    end
                end
                `FSP_OP_BLOCK_ERASE_A, `FSP_OP_BLOCK_ERASE_B: begin
                    if (byte_reg == `FSP_LEN_ADDR_CMD && !area_blocked) begin
                        kind_next = FSP_KIND_BLOCK;
                    end
                end
                `FSP_OP_CHIP_ERASE_A, `FSP_OP_CHIP_ERASE_B: begin
                    if (byte_reg == `FSP_LEN_SINGLE && guard_reg == 3'h0 && !otp_mode_reg) begin
                        kind_next = FSP_KIND_CHIP;
                    end
                end
                default: begin
                    kind_next = FSP_KIND_NONE;
                end
            endcase
        end
        unique case (kind_next)
            FSP_KIND_STATUS:  timer_next = 16'(`FSP_CYC(`FSP_T_STATUS_NS));
            FSP_KIND_PROGRAM: timer_next = 16'(`FSP_CYC(`FSP_T_PROGRAM_NS));
            FSP_KIND_SECTOR:  timer_next = 16'(`FSP_CYC(`FSP_T_SECTOR_NS));
            FSP_KIND_BLOCK:   timer_next = 16'(`FSP_CYC(`FSP_T_BLOCK_NS));
            FSP_KIND_CHIP:    timer_next = 16'(`FSP_CYC(`FSP_T_CHIP_NS));
            FSP_KIND_NONE:    timer_next = (timer_reg != 16'h0000) ? timer_reg - 16'h0001
                                                                   : 16'h0000;
        endcase
        status_next = 8'h00;
        status_next[`FSP_SB_BUSY] = busy;
        status_next[`FSP_SB_WEL] = wel_reg;
        status_next[`FSP_SB_GUARD_HI:`FSP_SB_GUARD_LO] = guard_reg;
        status_next[`FSP_SB_LOCK] = otp_mode_reg ? otp_lock_reg : lock_reg;
    end

    // self-timed cycle
    always_ff @(posedge CORE_CLK or posedge RESET) begin
        if (RESET) begin
            kind_reg  <= FSP_KIND_NONE;
            timer_reg <= 16'h0000;
        end else begin
            if (kind_next != FSP_KIND_NONE) begin
                kind_reg <= kind_next;
            end else if (cycle_done) begin
                kind_reg <= FSP_KIND_NONE;
            end
            timer_reg <= timer_next;
        end
    end

    // write latch
    always_ff @(posedge CORE_CLK or posedge RESET) begin
        if (RESET) begin
            wel_reg <= 1'b0;
        end else if (cycle_done) begin
            wel_reg <= 1'b0;
        end else if (frame_end && aligned && !busy && byte_reg == `FSP_LEN_SINGLE) begin
            if (op_reg == `FSP_OP_WRITE_ALLOW) begin
                wel_reg <= 1'b1;
            end else if (op_reg == `FSP_OP_WRITE_FORBID && !otp_mode_reg) begin
                wel_reg <= 1'b0;
            end
        end
    end

    // otp mode
    always_ff @(posedge CORE_CLK or posedge RESET) begin
        if (RESET) begin
            otp_mode_reg <= 1'b0;
        end else if (frame_end && aligned && !busy && byte_reg == `FSP_LEN_SINGLE) begin
            if (op_reg == `FSP_OP_OTP_ENTER) begin
                otp_mode_reg <= 1'b1;
            end else if (op_reg == `FSP_OP_WRITE_FORBID) begin
                otp_mode_reg <= 1'b0;
            end
        end
    end

    // non-volatile status bits
    always_ff @(posedge CORE_CLK or posedge RESET) begin
        if (RESET) begin
            wr_data_reg  <= 8'h00;
            guard_reg    <= `FSP_RST_GUARD;
            lock_reg     <= `FSP_RST_LOCK;
            otp_lock_reg <= `FSP_RST_OTP_LOCK;
        end else begin
            if (kind_next == FSP_KIND_STATUS) begin
                wr_data_reg <= b1_reg;
            end
            if (cycle_done && kind_reg == FSP_KIND_STATUS) begin
                if (otp_mode_reg) begin
                    otp_lock_reg <= 1'b1;
                end else begin
                    guard_reg <= wr_data_reg[`FSP_SB_GUARD_HI:`FSP_SB_GUARD_LO];
                    lock_reg  <= wr_data_reg[`FSP_SB_LOCK];
                end
            end
        end
    end

    // status snapshot for the link
    always_ff @(posedge CORE_CLK or posedge RESET) begin
        if (RESET) begin
            status_and_protect_reg <= 8'h00;
        end else begin
            status_and_protect_reg <= status_next;
        end
    end

endmodule : fsp_top

// >>> testbench/fsp_top_chk.sv
// Purpose: port checker for the flash status, guard and id logic
// Assumes: sees only fsp_top ports, link mode 0
// Notes:   frame tracking is cleared while select is high
`timescale 1ns/1ps
`include "fsp_consts.svh"

module fsp_top_chk
    import fsp_pkg::*;
#(
    parameter logic [7:0] MAKER_CODE   = 8'hA5,
    parameter logic [7:0] PART_CODE_HI = 8'h5A,
    parameter logic [7:0] PART_CODE_LO = 8'h3C
) (
    // core
    input wire logic CORE_CLK,
    input wire logic RESET,
    // link
    input wire logic SPI_CLK,
    input wire logic CS_N,
    input wire logic SERIAL_IN,
    input wire logic SERIAL_OUT,
    input wire logic SERIAL_OUT_OE_N,
    // guard pin
    input wire logic WP_N
);
    logic [6:0]  cnt_reg;
    logic [7:0]  op_reg;
    logic        sel_reg;
    logic [23:0] id_word;

    assign id_word = {MAKER_CODE, PART_CODE_HI, PART_CODE_LO};

    // bit count, opcode and selector of the frame
    always_ff @(posedge SPI_CLK or posedge CS_N or posedge RESET) begin
        if (RESET || CS_N) begin
            cnt_reg <= 7'h00;
            op_reg  <= 8'h00;
            sel_reg <= 1'b0;
        end else begin
            if (cnt_reg != 7'h7F) cnt_reg <= cnt_reg + 7'h01;
            if (cnt_reg < 7'h08) op_reg <= {op_reg[6:0], SERIAL_IN};
            if (cnt_reg == 7'h1F) sel_reg <= SERIAL_IN;
        end
    end

    sequence status_out_s;
        op_reg == `FSP_OP_STATUS_READ && cnt_reg >= 7'h08;
    endsequence
    sequence id_out_s;
        op_reg == `FSP_OP_ID_READ && cnt_reg >= 7'h08 && cnt_reg < 7'h20;
    endsequence

    out_release_a: assert property (
        @(posedge CORE_CLK) disable iff (RESET) CS_N |-> SERIAL_OUT_OE_N && !SERIAL_OUT)
        else $error("output not released with select high");
    opcode_quiet_a: assert property (
        @(posedge SPI_CLK) disable iff (RESET || CS_N) cnt_reg < 7'h08 |-> SERIAL_OUT_OE_N)
        else $error("output driven during opcode");
    status_answer_a: assert property (
        @(posedge SPI_CLK) disable iff (RESET || CS_N) status_out_s |-> !SERIAL_OUT_OE_N)
        else $error("status answer not driven");
    reserved_zero_a: assert property (
        @(posedge SPI_CLK) disable iff (RESET || CS_N)
        status_out_s ##0 (cnt_reg[2:0] inside {3'h1, 3'h2}) |-> SERIAL_OUT == 1'b0)
        else $error("reserved status bit not zero");
    status_repeat_a: assert property (
        @(posedge SPI_CLK) disable iff (RESET || CS_N)
        status_out_s ##0 (cnt_reg >= 7'h10) |-> SERIAL_OUT == $past(SERIAL_OUT, 8))
        else $error("status byte not repeated");
    id_read_a: assert property (
        @(posedge SPI_CLK) disable iff (RESET || CS_N)
        id_out_s |-> SERIAL_OUT == id_word[7'h1F - cnt_reg])
        else $error("id read bit wrong");
    release_id_a: assert property (
        @(posedge SPI_CLK) disable iff (RESET || CS_N)
        op_reg == `FSP_OP_ID_RELEASE && cnt_reg >= 7'h20
        |-> SERIAL_OUT == PART_CODE_LO[~cnt_reg[2:0]])
        else $error("release id bit wrong");
    pair_id_a: assert property (
        @(posedge SPI_CLK) disable iff (RESET || CS_N)
        op_reg == `FSP_OP_ID_PAIR && cnt_reg >= 7'h20 |-> SERIAL_OUT ==
        ((cnt_reg[3] ^ sel_reg) ? PART_CODE_LO[~cnt_reg[2:0]] : MAKER_CODE[~cnt_reg[2:0]]))
        else $error("pair id bit wrong");
endmodule : fsp_top_chk

bind fsp_top fsp_top_chk #(
    .MAKER_CODE  (MAKER_CODE),
    .PART_CODE_HI(PART_CODE_HI),
    .PART_CODE_LO(PART_CODE_LO)
) chk (
    .CORE_CLK       (CORE_CLK),
    .RESET          (RESET),
    .SPI_CLK        (SPI_CLK),
    .CS_N           (CS_N),
    .SERIAL_IN      (SERIAL_IN),
    .SERIAL_OUT     (SERIAL_OUT),
    .SERIAL_OUT_OE_N(SERIAL_OUT_OE_N),
    .WP_N           (WP_N)
);

// >>> testbench/fsp_host_model.sv
// Purpose: host link controller model, mode 0, 160 ns link clock
// Assumes: clock stands low outside frames
// Notes:   frame sends nbits from the top of tx, rx holds last bits seen
`timescale 1ns/1ps

module fsp_host_model (
    // link
    output logic     spi_clk,
    output logic     cs_n,
    output logic     serial_in,
    input wire logic serial_out
);
    initial begin
        spi_clk   = 1'b0;
        cs_n      = 1'b1;
        serial_in = 1'b0;
    end

    task automatic frame(input int nbits, input logic [63:0] tx, output logic [63:0] rx);
        rx = 64'h0;
        #37 cs_n = 1'b0;
        for (int i = 0; i < nbits; i++) begin
            serial_in = tx[63 - i];
            #80 spi_clk = 1'b1;
            rx = {rx[62:0], serial_out};
            #80 spi_clk = 1'b0;
        end
        #40 cs_n = 1'b1;
        serial_in = ~serial_in;
        #200;
    endtask : frame
endmodule : fsp_host_model

// >>> testbench/tb.sv
// Purpose: self-checking bench of fsp_top
// Assumes: host model drives the link, bench drives core inputs
// Notes:   waits cover the status write and chip erase cycle times
`timescale 1ns/1ps
`include "fsp_consts.svh"

module tb;
    import fsp_pkg::*;
    localparam logic [7:0] MK = 8'hA5; // arbitrary value
    localparam logic [7:0] PH = 8'h5A; // arbitrary value
    localparam logic [7:0] PL = 8'h3C; // arbitrary value
    logic        core_clk = 1'b0;
    logic        reset    = 1'b1;
    logic        wp_n     = 1'b1;
    wire         spi_clk, cs_n, serial_in, serial_out, serial_out_oe_n;
    int          failures = 0;
    int          checks   = 0;
    logic [63:0] rx;

    always #12.5 core_clk = ~core_clk;

    fsp_top #(.MAKER_CODE(MK), .PART_CODE_HI(PH), .PART_CODE_LO(PL)) uut (
        .CORE_CLK(core_clk), .RESET(reset), .SPI_CLK(spi_clk), .CS_N(cs_n),
        .SERIAL_IN(serial_in), .SERIAL_OUT(serial_out),
        .SERIAL_OUT_OE_N(serial_out_oe_n), .WP_N(wp_n));
    fsp_host_model host (.spi_clk(spi_clk), .cs_n(cs_n), .serial_in(serial_in),
        .serial_out(serial_out_oe_n ? ~serial_out : serial_out));

    task automatic check(input string what, input logic [23:0] exp, input logic [23:0] got);
        checks++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    task automatic stat(input string what, input logic [7:0] exp);
        host.frame(24, {`FSP_OP_STATUS_READ, 56'h0}, rx);
        check(what, {8'h00, exp, exp}, {8'h00, rx[15:0]});
    endtask : stat

    task automatic cmd(input logic [7:0] op, input logic [7:0] dat, input int nbits);
        host.frame(nbits, {op, dat, 48'h0}, rx);
    endtask : cmd

    task automatic test_ids;
        host.frame(40, {`FSP_OP_ID_READ, 56'h0}, rx);
        check("id read", {MK, PH, PL}, rx[31:8]);
        host.frame(48, {`FSP_OP_ID_RELEASE, 56'h0}, rx);
        check("release id", {8'h00, PL, PL}, {8'h00, rx[15:0]});
        host.frame(56, {`FSP_OP_ID_PAIR, 16'h0, 8'h00, 32'h0}, rx);
        check("pair id sel 0", {MK, PL, MK}, rx[23:0]);
        host.frame(56, {`FSP_OP_ID_PAIR, 16'h0, 8'h01, 32'h0}, rx);
        check("pair id sel 1", {PL, MK, PL}, rx[23:0]);
    endtask : test_ids

    task automatic test_latch;
        stat("status after reset", 8'h00);
        cmd(`FSP_OP_WRITE_ALLOW, 8'h00, 8);
        stat("latch set", 8'h02);
        cmd(`FSP_OP_WRITE_FORBID, 8'h00, 8);
        stat("latch cleared", 8'h00);
        cmd(`FSP_OP_WRITE_ALLOW, 8'h00, 9);
        stat("unaligned allow", 8'h00);
        cmd(`FSP_OP_STATUS_WRITE, 8'h9C, 16);
        stat("write without latch", 8'h00);
    endtask : test_latch

    task automatic test_status_write;
        cmd(`FSP_OP_WRITE_ALLOW, 8'h00, 8);
        cmd(`FSP_OP_STATUS_WRITE, 8'hFF, 24);
        stat("long status write", 8'h02);
        cmd(`FSP_OP_STATUS_WRITE, 8'hFF, 16);
        stat("busy during write", 8'h03);
        #12000;
        stat("after write", 8'h9C);
    endtask : test_status_write

    task automatic test_guard;
        cmd(`FSP_OP_WRITE_ALLOW, 8'h00, 8);
        host.frame(40, {`FSP_OP_PAGE_PROGRAM, 24'h000000, 8'hFF, 24'h0}, rx);
        cmd(`FSP_OP_CHIP_ERASE_B, 8'h00, 8);
        stat("guarded program and erase", 8'h9E);
        @(negedge core_clk) wp_n = 1'b0;
        #500;
        cmd(`FSP_OP_STATUS_WRITE, 8'h00, 16);
        stat("hardware guard", 8'h9E);
        @(negedge core_clk) wp_n = 1'b1;
        #500;
        cmd(`FSP_OP_STATUS_WRITE, 8'h00, 16);
        #12000;
        stat("guard cleared", 8'h00);
        cmd(`FSP_OP_WRITE_ALLOW, 8'h00, 8);
        cmd(`FSP_OP_CHIP_ERASE_A, 8'h00, 8);
        stat("chip erase busy", 8'h03);
        #52000;
        stat("chip erase done", 8'h00);
    endtask : test_guard

    task automatic test_erase;
        cmd(`FSP_OP_WRITE_ALLOW, 8'h00, 8);
        host.frame(40, {`FSP_OP_PAGE_PROGRAM, 24'h1F0000, 8'h5A, 24'h0}, rx);
        stat("program busy", 8'h03);
        #22000;
        cmd(`FSP_OP_WRITE_ALLOW, 8'h00, 8);
        host.frame(32, {`FSP_OP_SECTOR_ERASE, 24'h000000, 32'h0}, rx);
        stat("sector erase busy", 8'h03);
        #32000;
        cmd(`FSP_OP_WRITE_ALLOW, 8'h00, 8);
        host.frame(32, {`FSP_OP_BLOCK_ERASE_B, 24'h1F0000, 32'h0}, rx);
        stat("block erase busy", 8'h03);
        #42000;
        stat("erase done", 8'h00);
    endtask : test_erase

    task automatic test_otp;
        cmd(`FSP_OP_OTP_ENTER, 8'h00, 8);
        cmd(`FSP_OP_WRITE_ALLOW, 8'h00, 8);
        cmd(`FSP_OP_STATUS_WRITE, 8'h00, 16);
        #12000;
        stat("otp sealed", 8'h80);
        cmd(`FSP_OP_WRITE_FORBID, 8'h00, 8);
        stat("otp left", 8'h00);
    endtask : test_otp

    task automatic test_done;
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : test_done

    initial begin
        #1000000;
        failures++;
        test_done();
    end

    initial begin
        repeat (8) @(negedge core_clk);
        reset = 1'b0;
        repeat (4) @(negedge core_clk);
        test_latch();
        test_ids();
        test_status_write();
        test_guard();
        test_erase();
        test_otp();
        test_done();
    end
endmodule : tb
